// ===== hw/serial_port_defines.vh
`ifndef SERIAL_PORT_DEFINES_VH
`define SERIAL_PORT_DEFINES_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define P0_CONTROL_IDX 10'h080
`define P0_LINE_STATUS_IDX 10'h082
`define P0_TX_CHAR_IDX 10'h084
`define P0_RECEIVED_CHAR_IDX 10'h086
`define P0_RATE_DIVISOR_IDX 10'h088
`define P1_CONTROL_IDX 10'h010
`define P1_LINE_STATUS_IDX 10'h012
`define P1_TX_CHAR_IDX 10'h014
`define P1_RECEIVED_CHAR_IDX 10'h016
`define P1_RATE_DIVISOR_IDX 10'h018

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define CTL_MODE_LSB 0
`define CTL_PARITY_ON 3
`define CTL_EVEN 4
`define CTL_RX_EN 5
`define CTL_TX_EN 6
`define CTL_FLOW 9
`define CTL_NINTH_TX 10
`define CTL_SEND_BREAK 11
`define CTL_RESET 16'h0000
`define DIVISOR_RESET 16'h0000

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define STS_HS_IN 1
`define STS_TRANSMITTER_IDLE 2
`define STS_PER 3
`define STS_OER 4
`define STS_FER 5
`define STS_TX_HOLDING_EMPTY 6
`define STS_RDV 7
`define STS_RB8 8
`define STS_SHORT_BRK 9
`define STS_LONG_BRK 10

// ----------------------------------------------------------------
// frame modes and timing
// ----------------------------------------------------------------
`define MODE_ONE 3'h1
`define MODE_TWO 3'h2
`define MODE_THREE 3'h3
`define MODE_FOUR 3'h4
`define OVERSAMPLE 5'h10
`define MID_SAMPLE 4'h7
`define LAST_SAMPLE 4'hF

`endif

// ===== hw/serial_port.v
`timescale 1ns/1ps
`include "serial_port_defines.vh"

module serial_port #(
	parameter [9:0] CONTROL_IDX = `P0_CONTROL_IDX,
	parameter [9:0] STATUS_IDX = `P0_LINE_STATUS_IDX,
	parameter [9:0] TX_CHAR_IDX = `P0_TX_CHAR_IDX,
	parameter [9:0] RX_CHAR_IDX = `P0_RECEIVED_CHAR_IDX,
	parameter [9:0] DIVISOR_IDX = `P0_RATE_DIVISOR_IDX
)(
	input wire hclk, // bus clock
	input wire hresetn, // async reset, active low
	input wire hsel, // slave select
	input wire [31:0] haddr, // byte address
	input wire [1:0] htrans, // transfer type
	input wire hwrite, // write when high
	input wire [2:0] hsize, // transfer size
	input wire [31:0] hwdata, // write data
	input wire hready, // bus ready
	output reg hreadyout, // slave ready
	output reg [31:0] hrdata, // read data
	output reg hresp, // response, always okay
	input wire rxd, // serial receive line
	output reg txd, // serial transmit line
	input wire handshake_in, // clear-to-send style handshake input
	output reg receive_enable_handshake // high while receiver accepts data
);

	localparam RX_IDLE = 3'h0;
	localparam RX_START = 3'h1;
	localparam RX_DATA = 3'h2;
	localparam RX_PAR = 3'h3;
	localparam RX_STOP = 3'h4;
	localparam RX_BREAK = 3'h5;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg [15:0] control_reg;
	reg [15:0] divisor_reg;
	reg [15:0] div_cnt_reg;
	reg tick_reg;
	reg rxd_meta_reg, rxd_s_reg;
	reg hs_meta_reg, hs_s_reg;
	reg pend_reg, pend_write_reg;
	reg [9:0] pend_idx_reg;
	reg [7:0] hold_reg;
	reg hold_valid_reg;
	reg [11:0] tx_sh_reg;
	reg [3:0] tx_left_reg;
	reg [3:0] tx_cnt_reg;
	reg [2:0] rx_state_reg;
	reg [3:0] rx_cnt_reg;
	reg [3:0] rx_idx_reg;
	reg [8:0] rx_sh_reg;
	reg rx_par_reg;
	reg all_low_reg;
	reg [11:0] brk_cnt_reg;
	reg [7:0] rx_data_reg;
	reg rdv_reg, rb8_reg, fer_reg, oer_reg, per_reg;
	reg short_brk_reg, long_brk_reg;

	// ----------------------------------------------------------------
	// frame shape from mode and parity
	// ----------------------------------------------------------------
	wire [2:0] mode = control_reg[`CTL_MODE_LSB+2:`CTL_MODE_LSB];
	wire parity_on = control_reg[`CTL_PARITY_ON];
	wire flow_on = control_reg[`CTL_FLOW];
	wire ninth_tx_bit = control_reg[`CTL_NINTH_TX];
	wire mode_ok = (mode >= `MODE_ONE) && (mode <= `MODE_FOUR);
	reg [3:0] nd;
	reg np;
	always @*
	begin
		nd = 4'h8;
		np = 1'b0;
		case (mode)
			`MODE_ONE:
			begin
				nd = parity_on ? 4'h7 : 4'h8;
				np = parity_on;
			end
			`MODE_TWO:
				nd = 4'h9;
			`MODE_THREE:
			begin
				nd = parity_on ? 4'h8 : 4'h9;
				np = parity_on;
			end
			`MODE_FOUR:
			begin
				nd = 4'h7;
				np = 1'b0;
			end
			default:
			begin
				nd = 4'h8;
				np = 1'b0;
			end
		endcase
	end
	// m counts start, data, parity and stop bits
	wire [3:0] frame_m = nd + {3'h0, np} + 4'h2;
	wire [11:0] short_thr = {4'h0, frame_m, 4'h0};
	wire [11:0] long_thr = {3'h0, frame_m, 5'h00} + 12'h030;
	wire running = mode_ok && (divisor_reg != 16'h0000);
	wire rx_run = running && control_reg[`CTL_RX_EN];
	wire tx_run = running && control_reg[`CTL_TX_EN];

	// ----------------------------------------------------------------
	// bus decode: one wait state so read data comes from a flop
	// ----------------------------------------------------------------
	wire accept = hsel && htrans[1] && hready;
	wire do_acc = pend_reg;
	wire wr_ctl = do_acc && pend_write_reg && (pend_idx_reg == CONTROL_IDX);
	wire wr_sts = do_acc && pend_write_reg && (pend_idx_reg == STATUS_IDX);
	wire wr_tx = do_acc && pend_write_reg && (pend_idx_reg == TX_CHAR_IDX);
	wire wr_div = do_acc && pend_write_reg && (pend_idx_reg == DIVISOR_IDX);
	wire rd_rx = do_acc && !pend_write_reg && (pend_idx_reg == RX_CHAR_IDX);
	wire tx_holding_empty = !hold_valid_reg;
	wire transmitter_idle = !hold_valid_reg && (tx_left_reg == 4'h0);
	wire [15:0] status = {5'h00, long_brk_reg, short_brk_reg, rb8_reg,
		rdv_reg, tx_holding_empty, fer_reg, oer_reg, per_reg, transmitter_idle, hs_s_reg, 1'b0};
	reg [15:0] rd_word;
	always @*
	begin
		rd_word = 16'h0000;
		if (pend_idx_reg == CONTROL_IDX)
			rd_word = control_reg;
		else if (pend_idx_reg == STATUS_IDX)
			rd_word = status;
		else if (pend_idx_reg == RX_CHAR_IDX)
			rd_word = {8'h00, rx_data_reg};
		else if (pend_idx_reg == DIVISOR_IDX)
			rd_word = divisor_reg;
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pend_reg <= 1'b0;
			pend_write_reg <= 1'b0;
			pend_idx_reg <= 10'h000;
			hreadyout <= 1'b1;
			hrdata <= 32'h00000000;
			hresp <= 1'b0;
		end
		else
		begin
			hresp <= 1'b0;
			pend_reg <= accept;
			hreadyout <= !accept;
			if (accept)
			begin
				pend_write_reg <= hwrite;
				pend_idx_reg <= haddr[11:2];
			end
			if (do_acc)
				hrdata <= pend_write_reg ? 32'h00000000 : {16'h0000, rd_word};
		end
	end

	// ----------------------------------------------------------------
	// configuration and input synchronisers
	// ----------------------------------------------------------------
	wire tx_done = tick_reg && (tx_cnt_reg == `LAST_SAMPLE) &&
		(tx_left_reg == 4'h1);
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			control_reg <= `CTL_RESET;
			divisor_reg <= `DIVISOR_RESET;
			rxd_meta_reg <= 1'b1;
			rxd_s_reg <= 1'b1;
			hs_meta_reg <= 1'b0;
			hs_s_reg <= 1'b0;
		end
		else
		begin
			rxd_meta_reg <= rxd;
			rxd_s_reg <= rxd_meta_reg;
			hs_meta_reg <= handshake_in;
			hs_s_reg <= hs_meta_reg;
			if (wr_div)
				divisor_reg <= hwdata[15:0];
			// software's write wins over the automatic clear
			if (wr_ctl)
				control_reg <= hwdata[15:0];
			else if (tx_done)
				control_reg[`CTL_NINTH_TX] <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// 16x sampling tick
	// ----------------------------------------------------------------
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			div_cnt_reg <= 16'h0000;
			tick_reg <= 1'b0;
		end
		else if (divisor_reg == 16'h0000 || wr_div)
		begin
			div_cnt_reg <= 16'h0000;
			tick_reg <= 1'b0;
		end
		else if (div_cnt_reg >= divisor_reg - 16'h0001)
		begin
			div_cnt_reg <= 16'h0000;
			tick_reg <= 1'b1;
		end
		else
		begin
			div_cnt_reg <= div_cnt_reg + 16'h0001;
			tick_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------------
	wire [8:0] nd_mask = ~(9'h1FF << nd);
	wire [8:0] tx_data = {ninth_tx_bit, hold_reg} & nd_mask;
	wire tx_par = control_reg[`CTL_EVEN] ? ^tx_data : ~^tx_data;
	wire [11:0] tx_base = (12'hFFF << (nd + 4'h1)) | {2'b00, tx_data, 1'b0};
	wire [11:0] tx_frame = (np && !tx_par) ?
		(tx_base & ~(12'h001 << (nd + 4'h1))) : tx_base;
	// with flow control a low handshake input holds the next character
	wire tx_start = tx_run && hold_valid_reg && (tx_left_reg == 4'h0) &&
		(!flow_on || hs_s_reg);
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hold_reg <= 8'h00;
			hold_valid_reg <= 1'b0;
			tx_sh_reg <= 12'hFFF;
			tx_left_reg <= 4'h0;
			tx_cnt_reg <= 4'h0;
			txd <= 1'b1;
		end
		else
		begin
			// a write into a full holding register is dropped
			if (wr_tx && !hold_valid_reg)
			begin
				hold_reg <= hwdata[7:0];
				hold_valid_reg <= 1'b1;
			end
			else if (tx_start)
				hold_valid_reg <= 1'b0;
			if (tx_start)
			begin
				tx_sh_reg <= tx_frame;
				tx_left_reg <= frame_m;
				tx_cnt_reg <= 4'h0;
			end
			else if (!tx_run)
				tx_left_reg <= 4'h0;
			else if (tick_reg && tx_left_reg != 4'h0)
			begin
				tx_cnt_reg <= tx_cnt_reg + 4'h1;
				if (tx_cnt_reg == `LAST_SAMPLE)
				begin
					tx_sh_reg <= {1'b1, tx_sh_reg[11:1]};
					tx_left_reg <= tx_left_reg - 4'h1;
				end
			end
			if (control_reg[`CTL_SEND_BREAK])
				txd <= 1'b0;
			else
				txd <= (tx_left_reg != 4'h0) ? tx_sh_reg[0] : 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// receiver: mid-bit sampling on the 16x tick
	// ----------------------------------------------------------------
	// sampling each bit at its centre leaves half a bit of drift over a
	// whole frame, enough for the tolerated rate error
	wire rx_mid = tick_reg && (rx_cnt_reg == `LAST_SAMPLE);
	wire [8:0] rx_word = rx_sh_reg;
	wire rx_exp_par = control_reg[`CTL_EVEN] ? ^rx_word : ~^rx_word;
	wire stop_now = (rx_state_reg == RX_STOP) && rx_mid;
	wire ninth_mode = (mode == `MODE_TWO) || (mode == `MODE_THREE);
	wire keep_char = !((mode == `MODE_TWO) && !rx_word[8]);
	wire deliver = stop_now && keep_char;
	wire par_chk = np && ((mode == `MODE_ONE) || (mode == `MODE_THREE));
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rx_state_reg <= RX_IDLE;
			rx_cnt_reg <= 4'h0;
			rx_idx_reg <= 4'h0;
			rx_sh_reg <= 9'h000;
			rx_par_reg <= 1'b0;
			all_low_reg <= 1'b0;
			brk_cnt_reg <= 12'h000;
		end
		else if (!rx_run)
		begin
			rx_state_reg <= RX_IDLE;
			brk_cnt_reg <= 12'h000;
		end
		else
		begin
			if (tick_reg)
			begin
				if (rxd_s_reg)
					brk_cnt_reg <= 12'h000;
				else if (stop_now && !all_low_reg)
					brk_cnt_reg <= 12'h000;
				else if (brk_cnt_reg != 12'hFFF)
					brk_cnt_reg <= brk_cnt_reg + 12'h001;
				rx_cnt_reg <= rx_cnt_reg + 4'h1;
			end
			case (rx_state_reg)
				RX_IDLE:
					if (!rxd_s_reg)
					begin
						rx_state_reg <= RX_START;
						rx_cnt_reg <= 4'h0;
					end
				RX_START:
					if (tick_reg && rx_cnt_reg == `MID_SAMPLE)
					begin
						rx_state_reg <= rxd_s_reg ? RX_IDLE : RX_DATA;
						rx_cnt_reg <= 4'h0;
						rx_idx_reg <= 4'h0;
						rx_sh_reg <= 9'h000;
						all_low_reg <= 1'b1;
					end
				RX_DATA:
					if (rx_mid)
					begin
						rx_sh_reg[rx_idx_reg] <= rxd_s_reg;
						all_low_reg <= all_low_reg && !rxd_s_reg;
						rx_idx_reg <= rx_idx_reg + 4'h1;
						if (rx_idx_reg == nd - 4'h1)
							rx_state_reg <= np ? RX_PAR : RX_STOP;
					end
				RX_PAR:
					if (rx_mid)
					begin
						rx_par_reg <= rxd_s_reg;
						all_low_reg <= all_low_reg && !rxd_s_reg;
						rx_state_reg <= RX_STOP;
					end
				RX_STOP:
					if (rx_mid)
						rx_state_reg <= rxd_s_reg ? RX_IDLE : RX_BREAK;
				RX_BREAK:
					if (rxd_s_reg)
						rx_state_reg <= RX_IDLE;
				default:
					rx_state_reg <= RX_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// receive data register and sticky status flags
	// ----------------------------------------------------------------
	// a flag set in the same cycle as a software clear stays set
	wire in_brk = (rx_state_reg == RX_BREAK);
	wire set_fer = stop_now && !rxd_s_reg;
	wire set_oer = deliver && rdv_reg && !rd_rx;
	wire set_per = deliver && par_chk && (rx_par_reg != rx_exp_par);
	wire set_rb8 = deliver && ninth_mode && (nd == 4'h9) && rx_word[8];
	wire set_short = in_brk && (brk_cnt_reg > short_thr);
	wire set_long = in_brk && (brk_cnt_reg > long_thr);
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rx_data_reg <= 8'h00;
			rdv_reg <= 1'b0;
			rb8_reg <= 1'b0;
			fer_reg <= 1'b0;
			oer_reg <= 1'b0;
			per_reg <= 1'b0;
			short_brk_reg <= 1'b0;
			long_brk_reg <= 1'b0;
			receive_enable_handshake <= 1'b1;
		end
		else
		begin
			if (deliver)
				rx_data_reg <= rx_word[7:0];
			if (deliver)
				rdv_reg <= 1'b1;
			else if (rd_rx)
				rdv_reg <= 1'b0;
			// writing zero clears a flag, writing one leaves it
			rb8_reg <= set_rb8 ||
				(rb8_reg && !(wr_sts && !hwdata[`STS_RB8]));
			fer_reg <= set_fer ||
				(fer_reg && !(wr_sts && !hwdata[`STS_FER]));
			oer_reg <= set_oer ||
				(oer_reg && !(wr_sts && !hwdata[`STS_OER]));
			per_reg <= set_per ||
				(per_reg && !(wr_sts && !hwdata[`STS_PER]));
			short_brk_reg <= set_short ||
				(short_brk_reg && !(wr_sts && !hwdata[`STS_SHORT_BRK]));
			long_brk_reg <= set_long ||
				(long_brk_reg && !(wr_sts && !hwdata[`STS_LONG_BRK]));
			// a delivery in the read cycle keeps data unread
			if (flow_on)
				receive_enable_handshake <=
					!((rdv_reg && !rd_rx) || deliver);
			else
				receive_enable_handshake <= 1'b1;
		end
	end

endmodule

// ===== bench/serial_port_props.sv
`timescale 1ns/1ps
`include "serial_port_defines.vh"
// ----
// port checker
// ----
module serial_port_props (
	input wire hclk, // bus clock
	input wire hresetn, // reset, active low
	input wire hsel, // select
	input wire [31:0] haddr, // byte address
	input wire [1:0] htrans, // transfer type
	input wire hwrite, // write
	input wire [2:0] hsize, // size
	input wire [31:0] hwdata, // write data
	input wire hready, // bus ready
	input wire hreadyout, // slave ready
	input wire [31:0] hrdata, // read data
	input wire hresp, // response
	input wire rxd, // serial in
	input wire txd, // serial out
	input wire handshake_in, // handshake in
	input wire receive_enable_handshake // handshake out
);
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	wire taken = hsel && htrans[1] && hready;
	wire [9:0] idx = haddr[11:2];
	wire rx_touch = idx == `P0_RECEIVED_CHAR_IDX || idx == `P0_CONTROL_IDX;
	reg [2:0] since_rx; // cycles since a char read or control access
	reg [2:0] hs_same; // cycles the handshake input kept its level
	reg hs_last;
	// saturating counts: only short spans matter here
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			since_rx <= 3'h7;
			hs_same <= 3'h0;
			hs_last <= 1'b1;
		end
		else
		begin
			hs_last <= handshake_in;
			if (handshake_in != hs_last)
				hs_same <= 3'h0;
			else if (hs_same != 3'h7)
				hs_same <= hs_same + 3'h1;
			if (taken && rx_touch)
				since_rx <= 3'h0;
			else if (since_rx != 3'h7)
				since_rx <= since_rx + 3'h1;
		end
	end
	sequence one_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	sequence bit_held;
		$stable(txd) [*8] ##1 $stable(txd) [*7];
	endsequence
	sequence status_read;
		taken && !hwrite && idx == `P0_LINE_STATUS_IDX && hs_same >= 3'h4;
	endsequence
	chk_one_wait: assert property (taken |=> one_wait)
		else $error("transfer did not take one wait");
	chk_wait_cause: assert property ($fell(hreadyout) |-> $past(taken))
		else $error("wait state without a transfer");
	chk_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	chk_upper_zero: assert property (hrdata[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	chk_data_stands: assert property ($changed(hrdata) |-> $rose(hreadyout))
		else $error("read data moved outside a data phase");
	chk_bit_length: assert property ($changed(txd) |=> bit_held)
		else $error("serial bit shorter than sixteen clocks");
	chk_enable_rise: assert property ($rose(receive_enable_handshake)
		|-> since_rx <= 3'h4)
		else $error("receive enable rose without a read");
	chk_level_mirror: assert property (status_read |-> ##2
		hrdata[1] == $past(handshake_in, 2))
		else $error("status bit 1 differs from handshake input");
endmodule

// ===== bench/remote_port.sv
`timescale 1ns/1ps
// ----
// far-end serial port
// ----
module remote_port (
	input wire clk, // bench clock
	input wire txd, // line from the port
	output reg rxd, // line into the port
	output reg handshake // high while we accept data
);
	integer bit_cycles = 16; // divisor one gives sixteen clocks a bit
	reg [10:0] got; // last frame from txd, stop bit on top
	// the line idles high, as a pulled-up line does
	initial
	begin
		rxd = 1'b1;
		handshake = 1'b1;
	end
	// low start, lsb first, then the stop level asked
	task send(input [9:0] d, input integer n, input stp);
		integer i;
		begin
			rxd <= 1'b0;
			repeat (bit_cycles) @(posedge clk);
			for (i = 0; i < n; i = i + 1)
			begin
				rxd <= d[i];
				repeat (bit_cycles) @(posedge clk);
			end
			rxd <= stp;
			repeat (bit_cycles) @(posedge clk);
			rxd <= 1'b1;
		end
	endtask
	task brk(input integer n);
		begin
			rxd <= 1'b0;
			repeat (n * bit_cycles) @(posedge clk);
			rxd <= 1'b1;
		end
	endtask
	// samples mid-bit so small skew of the sender does not matter
	task cap(input integer n);
		integer i;
		begin
			while (txd !== 1'b0)
				@(posedge clk);
			repeat (bit_cycles / 2) @(posedge clk);
			got = 11'h000;
			for (i = 0; i <= n; i = i + 1)
			begin
				repeat (bit_cycles) @(posedge clk);
				got[i] = txd;
			end
		end
	endtask
endmodule

// ===== bench/async_serial_port_multidrop_test.sv
`timescale 1ns/1ps
`include "serial_port_defines.vh"
module async_serial_port_multidrop_test;
	localparam [9:0] CTL = `P0_CONTROL_IDX;
	localparam [9:0] STS = `P0_LINE_STATUS_IDX;
	localparam [9:0] TXC = `P0_TX_CHAR_IDX;
	localparam [9:0] RXC = `P0_RECEIVED_CHAR_IDX;
	localparam [9:0] DIV = `P0_RATE_DIVISOR_IDX;
	localparam [15:0] EN = 16'h0060; // receiver and transmitter on
	localparam [15:0] IDLE = 16'h0046; // holding empty, idle, handshake high
	reg hclk, hresetn, hsel, hwrite;
	reg [1:0] htrans;
	reg [31:0] haddr, hwdata, q;
	reg [15:0] m;
	wire [31:0] hrdata;
	wire hreadyout, hresp, rxd, txd, handshake_in, receive_enable_handshake;
	integer errors = 0;
	integer samples_checked = 0;
	integer i;
	serial_port dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .rxd(rxd), .txd(txd),
		.handshake_in(handshake_in),
		.receive_enable_handshake(receive_enable_handshake));
	remote_port far (.clk(hclk), .txd(txd), .rxd(rxd),
		.handshake(handshake_in));
	task check(input string what, input [31:0] seen, input [31:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (seen !== exp)
			begin
				errors = errors + 1;
				$display("Error %s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	task end_sim;
		begin
			if (errors == 0 && samples_checked > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	task wait_rdy;
		begin
			@(posedge hclk);
			while (hreadyout !== 1'b1)
				@(posedge hclk);
		end
	endtask
	task xfer(input w, input [9:0] a, input [15:0] d);
		begin
			hsel <= 1'b1;
			htrans <= 2'h2;
			hwrite <= w;
			haddr <= {20'h00000, a, 2'h0};
			wait_rdy;
			hsel <= 1'b0;
			htrans <= 2'h0;
			hwdata <= {16'h0000, d};
			wait_rdy;
			q = hrdata;
		end
	endtask
	task wr(input [9:0] a, input [15:0] d);
		xfer(1'b1, a, d);
	endtask
	task rdchk(input string what, input [9:0] a, input [31:0] e);
		begin
			xfer(1'b0, a, 16'h0000);
			check(what, q, e);
		end
	endtask
	task pause;
		repeat (6) @(posedge hclk);
	endtask
	task t_reset;
		begin
			rdchk("status", STS, IDLE);
			rdchk("divisor", DIV, 32'h0);
			rdchk("unmapped", 10'h3FF, 32'h0);
			wr(DIV, 16'h0001);
			rdchk("divisor", DIV, 32'h1);
		end
	endtask
	task t_tx;
		begin
			wr(CTL, EN | 16'h0403);
			fork
				far.cap(9);
				begin
					wr(TXC, 16'h00A5);
					rdchk("busy", STS, 16'h0042);
				end
			join
			check("nine bit frame", far.got, 32'h3A5);
			repeat (16) @(posedge hclk);
			rdchk("control", CTL, EN | 16'h0003);
			rdchk("status", STS, IDLE);
			// parity asked for but mode four has none
			wr(CTL, EN | 16'h0018 | 16'h0004);
			fork
				far.cap(7);
				wr(TXC, 16'h0053);
			join
			check("seven bit frame", far.got, 32'h0D3);
			repeat (16) @(posedge hclk);
			// send break forces the line low, release brings idle high
			wr(CTL, EN | 16'h0804);
			repeat (20) @(posedge hclk);
			check("break out", txd, 32'h0);
			wr(CTL, EN | 16'h0004);
			repeat (2) @(posedge hclk);
			check("line idle", txd, 32'h1);
		end
	endtask
	task t_rx;
		begin
			wr(CTL, EN | 16'h0003);
			far.send(10'h13C, 9, 1'b1);
			pause;
			rdchk("status", STS, IDLE | 16'h0180);
			fork
				far.send(10'h05A, 9, 1'b1);
				rdchk("char", RXC, 32'h3C);
			join
			pause;
			rdchk("status", STS, IDLE | 16'h0180);
			rdchk("char", RXC, 32'h5A);
			rdchk("status", STS, IDLE | 16'h0100);
			wr(STS, 16'h0000);
			rdchk("status", STS, IDLE);
			wr(CTL, EN | 16'h0009);
			far.send(10'h015, 8, 1'b1);
			pause;
			rdchk("status", STS, IDLE | 16'h0080);
			far.send(10'h0AA, 8, 1'b1);
			pause;
			rdchk("status", STS, IDLE | 16'h0098);
			rdchk("char", RXC, 32'h2A);
			wr(STS, 16'h0000);
		end
	endtask
	task t_mode2;
		begin
			wr(CTL, EN | 16'h0002);
			far.send(10'h077, 9, 1'b0);
			pause;
			rdchk("status", STS, IDLE | 16'h0020);
			far.send(10'h111, 9, 1'b1);
			pause;
			rdchk("status", STS, IDLE | 16'h01A0);
			rdchk("char", RXC, 32'h11);
			wr(STS, 16'h0000);
		end
	endtask
	task t_break;
		begin
			wr(CTL, EN | 16'h0004);
			for (i = 12; i < 24; i = i + 11)
			begin
				far.brk(i);
				pause;
				xfer(1'b0, STS, 16'h0000);
				check("break", q & 32'h620,
					i > 21 ? 32'h620 : 32'h220);
				xfer(1'b0, RXC, 16'h0000);
				wr(STS, 16'h0000);
			end
		end
	endtask
	task t_flow;
		begin
			wr(CTL, EN | 16'h0203); // flow control on, mode three
			far.handshake <= 1'b0;
			pause;
			rdchk("status", STS, 16'h0044);
			far.send(10'h081, 9, 1'b1);
			pause;
			check("enable", receive_enable_handshake, 32'h0);
			rdchk("char", RXC, 32'h81);
			repeat (4) @(posedge hclk);
			check("enable", receive_enable_handshake, 32'h1);
			far.handshake <= 1'b1;
		end
	endtask
	task t_stop;
		for (i = 0; i < 5; i = i + 1)
		begin
			m = (i == 0) ? 16'h0000 : i[15:0] + 16'h0004;
			if (i == 4)
			begin
				wr(DIV, 16'h0000);
				m = 16'h0003;
			end
			wr(CTL, EN | m);
			far.send(10'h1FF, 9, 1'b1);
			pause;
			rdchk("stopped", STS, IDLE);
		end
	endtask
	initial
	begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset;
		t_tx;
		t_rx;
		t_mode2;
		t_break;
		t_flow;
		t_stop;
		end_sim;
	end
	initial
	begin
		#100000;
		errors = errors + 1;
		end_sim;
	end
endmodule
bind serial_port serial_port_props chk (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rxd(rxd),
	.txd(txd), .handshake_in(handshake_in),
	.receive_enable_handshake(receive_enable_handshake));
